//--- rtl/aoc_fifo.sv
// Purpose: result queue between conversion core and output register
// Assumes: DEPTH is a power of two
// Notes: flip-flop storage; full stalls the filling side
`timescale 1ns/1ps
module aoc_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // streams
    aoc_stream_if.snk wr,
    aoc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire empty = (wp_r == rp_r);
    wire push = wr.valid && !full;
    wire pop = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= wr.data;
        end
    end

endmodule

//--- rtl/aoc_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 200 MHz core clock, AXI4-Lite register access
// Notes: register offsets, control and pin bit positions and timing counts live here
package aoc_pkg;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W = 16;
    localparam int CLK_NS = 5;
    localparam int CONV_TIME_NS = 600;
    // least time: round up to whole cycles
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_CYCLES_DEF = 64;
    localparam int SCLK_HALF = 4;
    localparam int SCLK_MID = SCLK_HALF / 2;
    localparam logic [4:0] BITS_PER_WORD = 5'h10;

    // ------------------------------------------------------------
    // synchronised pin vector layout
    // ------------------------------------------------------------
    localparam int PIN_N = 11;
    localparam int P_CNV = 0;
    localparam int P_CS = 1;
    localparam int P_RD = 2;
    localparam int P_RST = 3;
    localparam int P_PD = 4;
    localparam int P_REF_POWERDOWN = 5;
    localparam int P_REFBUF_POWERDOWN = 6;
    localparam int P_SER = 7;
    localparam int P_EXTCLK = 8;
    localparam int P_INV = 9;
    localparam int P_SCLK = 10;
    localparam logic [PIN_N-1:0] PIN_IDLE = 11'h007;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam int CTRL_SOFT_START = 0;
    localparam int CTRL_HOLD_OFF = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_LATCH,
        ST_CAL
    } aoc_state_t;

    function automatic logic aoc_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    function automatic logic aoc_fall(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

endpackage

//--- rtl/aoc_stream_if.sv
// Purpose: valid/ready word stream between converter and output queue
// Assumes: single clock domain
// Notes: src drives data and valid, snk drives ready
`timescale 1ns/1ps
interface aoc_stream_if #(parameter int W = 16);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

//--- rtl/aoc_top.sv
// Purpose: conversion, busy, calibration and output port control
// Assumes: pins asynchronous to core_clk, analog result on core_result
// Notes: serial clock is sampled, not used as a clock
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module aoc_top import aoc_pkg::*; #(
    parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // host control pins
    input wire logic convert_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic reset_in,
    input wire logic power_down_input,
    input wire logic ref_powerdown,
    input wire logic refbuf_powerdown,
    input wire logic serial_parallel_select,
    input wire logic clock_source_select,
    input wire logic serial_clock_invert,
    input wire logic sclk_in,
    // analog core
    input wire logic [DATA_W-1:0] core_result,
    output logic sample_hold,
    output logic ref_enable,
    output logic refbuf_enable,
    output logic low_power,
    // output port
    output logic busy,
    output logic [10:0] data_lo,
    output logic [10:0] data_lo_oe_n,
    output logic parallel_bit_eleven,
    output logic eleven_oe_n,
    output logic [3:0] data_hi,
    output logic data_hi_oe_n,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [PIN_N-1:0] meta_r;
    logic [PIN_N-1:0] pin_r;
    logic [PIN_N-1:0] prev_r;
    wire [PIN_N-1:0] pins = {sclk_in, serial_clock_invert,
        clock_source_select, serial_parallel_select, refbuf_powerdown,
        ref_powerdown, power_down_input, reset_in, rd_n, cs_n,
        convert_start_n};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= PIN_IDLE;
            pin_r <= PIN_IDLE;
            prev_r <= PIN_IDLE;
        end else begin
            meta_r <= pins;
            pin_r <= meta_r;
            prev_r <= pin_r;
        end
    end

    wire rst_s = pin_r[P_RST];
    wire pd_s = pin_r[P_PD];
    wire ser_s = pin_r[P_SER];
    wire slave_s = pin_r[P_EXTCLK];
    wire inv_s = pin_r[P_INV];
    wire cnv_fall = aoc_fall(prev_r[P_CNV], pin_r[P_CNV]);
    wire rst_fall = aoc_fall(prev_r[P_RST], pin_r[P_RST]);
    wire sclk_rise = aoc_rise(prev_r[P_SCLK], pin_r[P_SCLK]);
    wire sclk_fall = aoc_fall(prev_r[P_SCLK], pin_r[P_SCLK]);
    wire rd_rise = aoc_rise(prev_r[P_RD], pin_r[P_RD]);
    wire bus_en = !pin_r[P_CS] && !pin_r[P_RD];

    // ------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic soft_start_r;
    logic [7:0] err_cnt_r;
    logic [DATA_W-1:0] out_word_r;
    logic word_ok_r;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    aoc_state_t state_r;
    aoc_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [DATA_W-1:0] res_r;
    logic conv_done;

    aoc_stream_if #(.W(DATA_W)) q_in();
    aoc_stream_if #(.W(DATA_W)) q_out();

    // power-down and software hold-off only gate new starts
    wire start_ok = (cnv_fall || soft_start_r) && !pd_s
        && !ctrl_r[CTRL_HOLD_OFF];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        conv_done = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = ST_CONV;
                    cnt_nxt = CNT_W'(CONV_CYCLES - 1);
                end
            end
            ST_CONV: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_LATCH;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_LATCH: begin
                // full queue stalls here with busy still high
                if (q_in.ready) begin
                    state_nxt = ST_IDLE;
                    conv_done = 1'b1;
                end
            end
            ST_CAL: begin
                // start edges fall through unused here
                if (cnt_r == '0) begin
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (rst_s) begin
            state_nxt = ST_IDLE;
            conv_done = 1'b0;
        end else if (rst_fall) begin
            state_nxt = ST_CAL;
            cnt_nxt = CNT_W'(CAL_CYCLES - 1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            busy <= 1'b0;
            sample_hold <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            busy <= (state_nxt != ST_IDLE);
            sample_hold <= (state_nxt == ST_CONV);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            res_r <= '0;
        end else if (state_r == ST_CONV && cnt_r == '0) begin
            res_r <= core_result;
        end
    end

    assign q_in.data = res_r;
    assign q_in.valid = (state_r == ST_LATCH) && !rst_s;

    aoc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr(q_in),
        .rd(q_out)
    );

    // ------------------------------------------------------------
    // output shift register and serial engine
    // ------------------------------------------------------------
    logic [DATA_W-1:0] sr_r;
    logic [4:0] bits_r;
    logic sdo_r;
    logic flag_r;
    logic [2:0] div_r;
    logic sclk_out_r;

    wire load = !word_ok_r && q_out.valid;
    assign q_out.ready = !word_ok_r;
    wire reading = (bits_r != '0);
    wire master = ser_s && !slave_s;
    // cs gates the external clock
    wire slave_ev = ser_s && slave_s && !pin_r[P_CS]
        && (inv_s ? sclk_fall : sclk_rise);
    wire div_end = (div_r == 3'(SCLK_HALF - 1));
    // update mid low phase so both sclk edges see stable data
    wire master_ev = master && bus_en && word_ok_r && !sclk_out_r
        && (div_r == 3'(SCLK_MID));
    wire shift_ev = (slave_ev || master_ev) && word_ok_r;
    wire last_bit = (bits_r == BITS_PER_WORD - 1'b1);
    wire drop = conv_done && reading && ser_s && slave_s;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            sclk_out_r <= 1'b0;
        end else if (master && bus_en && word_ok_r) begin
            div_r <= div_end ? '0 : div_r + 1'b1;
            if (div_end) begin
                sclk_out_r <= !sclk_out_r;
            end
        end else begin
            div_r <= '0;
            sclk_out_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sr_r <= '0;
            bits_r <= '0;
            sdo_r <= 1'b0;
            word_ok_r <= 1'b0;
            out_word_r <= '0;
        end else if (drop) begin
            bits_r <= '0;
            word_ok_r <= 1'b0;
        end else if (load) begin
            sr_r <= q_out.data;
            out_word_r <= q_out.data;
            word_ok_r <= 1'b1;
        end else if (shift_ev) begin
            sdo_r <= sr_r[DATA_W-1];
            sr_r <= {sr_r[DATA_W-2:0], 1'b0};
            bits_r <= last_bit ? '0 : bits_r + 1'b1;
            if (last_bit) begin
                word_ok_r <= 1'b0;
            end
        end else if (!ser_s && rd_rise && !prev_r[P_CS]) begin
            word_ok_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= 1'b0;
            err_cnt_r <= '0;
        end else begin
            flag_r <= drop;
            if (drop) begin
                err_cnt_r <= err_cnt_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    wire [10:0] lo_nxt = ser_s
        ? {1'b0, sclk_out_r, sdo_r, 8'h00} : out_word_r[10:0];
    wire [10:0] lo_oe_nxt = ser_s
        ? {1'b1, !master, !bus_en, 8'hFF} : {11{!bus_en}};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_lo <= '0;
            data_lo_oe_n <= '1;
            parallel_bit_eleven <= 1'b0;
            eleven_oe_n <= 1'b1;
            data_hi <= '0;
            data_hi_oe_n <= 1'b1;
        end else begin
            data_lo <= lo_nxt;
            data_lo_oe_n <= lo_oe_nxt;
            parallel_bit_eleven <= ser_s ? flag_r : out_word_r[11];
            eleven_oe_n <= ser_s ? 1'b0 : !bus_en;
            data_hi <= out_word_r[15:12];
            data_hi_oe_n <= ser_s || !bus_en;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ref_enable <= 1'b0;
            refbuf_enable <= 1'b0;
            low_power <= 1'b0;
        end else begin
            ref_enable <= !pin_r[P_REF_POWERDOWN];
            refbuf_enable <= !pin_r[P_REFBUF_POWERDOWN];
            low_power <= pd_s && (state_nxt == ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_got_r;
    logic w_got_r;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    wire wr_ctrl = wr_go && (awaddr_r == ADDR_CTRL) && wstrb_r[0];
    wire wr_hit = (awaddr_r == ADDR_CTRL) || (awaddr_r == ADDR_STATUS)
        || (awaddr_r == ADDR_RESULT);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_w = {16'h0000, err_cnt_r, 4'h0, word_ok_r,
        low_power, state_r == ST_CAL, busy};
    wire rd_ok;
    wire [31:0] rd_val;

    assign rd_ok = (s_axi_araddr == ADDR_CTRL)
        || (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_RESULT);
    assign rd_val = (s_axi_araddr == ADDR_CTRL) ? {30'h0, ctrl_r}
        : (s_axi_araddr == ADDR_STATUS) ? status_w
        : (s_axi_araddr == ADDR_RESULT) ? {16'h0000, out_word_r} : 32'h0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RESET;
            soft_start_r <= 1'b0;
        end else begin
            soft_start_r <= wr_ctrl && wdata_r[CTRL_SOFT_START];
            if (wr_ctrl) begin
                ctrl_r[CTRL_HOLD_OFF] <= wdata_r[CTRL_HOLD_OFF];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

//--- tb/aoc_checker.sv
// Purpose: port properties of the converter control block
// Assumes: pin levels held five cycles have crossed the synchroniser
// Notes: bound into aoc_top at the foot of this file
`timescale 1ns/1ps
module aoc_checker #(
    parameter int CAL_CYCLES = 64
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // host pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic reset_in,
    input wire logic power_down_input,
    input wire logic ref_powerdown,
    input wire logic serial_parallel_select,
    // device outputs
    input wire logic sample_hold,
    input wire logic ref_enable,
    input wire logic busy,
    input wire logic [10:0] data_lo_oe_n,
    input wire logic parallel_bit_eleven,
    input wire logic data_hi_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // settled levels only: the two-flop sync blurs single-cycle ties
    property p_ref;
        ($stable(ref_powerdown) && nrst)[*5]
            |-> ref_enable == !ref_powerdown;
    endproperty
    a_ref: assert property (p_ref) else $error("ref enable wrong");
    property p_hold; sample_hold |-> busy; endproperty
    a_hold: assert property (p_hold) else $error("hold w/o busy");
    property p_abort; reset_in[*4] |-> !sample_hold; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_cal; $fell(reset_in) |-> ##[1:5] $rose(busy); endproperty
    a_cal: assert property (p_cal) else $error("no cal busy");
    property p_oe_on;
        (!cs_n && !rd_n && !serial_parallel_select)[*5] |-> !data_hi_oe_n;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("bus not on");
    property p_oe_off;
        cs_n[*5] |-> data_hi_oe_n && (&data_lo_oe_n);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus not off");
    property p_flag;
        serial_parallel_select[*6] ##0 parallel_bit_eleven
            |=> !parallel_bit_eleven;
    endproperty
    a_flag: assert property (p_flag) else $error("flag too long");
    property p_pd; power_down_input[*6] |-> !$rose(sample_hold); endproperty
    a_pd: assert property (p_pd) else $error("start in pd");
    cover property ($fell(busy));
    cover property (serial_parallel_select && parallel_bit_eleven);
    cover property (!data_hi_oe_n);
endmodule
bind aoc_top aoc_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.*);

//--- tb/aoc_host_model.sv
// Purpose: host side of the converter pins
// Assumes: slave serial mode, bench calls the tasks
// Notes: serial clock stands low outside frames
`timescale 1ns/1ps
module aoc_host_model (
    // clock and sampled data
    input wire logic core_clk,
    input wire logic data_bit,
    // host pins
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic sclk_in = 1'b0,
    output logic ref_powerdown = 1'b0,
    output logic refbuf_powerdown = 1'b0
);
    // buffer never off while the internal reference is in use
    task automatic set_ref(input logic v);
        @(posedge core_clk);
        ref_powerdown <= v;
        refbuf_powerdown <= v;
    endtask
    // both strobes low enable the bus
    task automatic bus(input logic on);
        @(posedge core_clk);
        cs_n <= !on;
        rd_n <= !on;
    endtask
    // 125 ns link clock, msb first; sel low holds cs high so the edges are ignored
    task automatic shift(input int k, input logic sel, output logic [15:0] w);
        w = 16'h0;
        bus(sel);
        #62.5;
        repeat (k) begin
            sclk_in = 1'b1;
            #62.5 sclk_in = 1'b0;
            #62.5 w = {w[14:0], data_bit};
        end
        bus(1'b0);
    endtask
endmodule

//--- tb/test_adc_conversion_output_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: slave serial clock, calibration cut to 16 cycles
// Notes: outputs sampled on the falling clock edge
`timescale 1ns/1ps
module test_adc_conversion_output_control import aoc_pkg::*; ;
    localparam int CAL = 16;
    logic core_clk = 1'b0, nrst = 1'b0, convert_start_n = 1'b1;
    logic reset_in = 1'b0, power_down_input = 1'b0;
    logic serial_parallel_select = 1'b0, serial_clock_invert = 1'b0;
    logic clock_source_select = 1'b1;
    logic [DATA_W-1:0] core_result = 16'h1234;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sample_hold, ref_enable, refbuf_enable, low_power;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic cs_n, rd_n, sclk_in, ref_powerdown, refbuf_powerdown, busy;
    logic [10:0] data_lo, data_lo_oe_n;
    logic parallel_bit_eleven, eleven_oe_n, data_hi_oe_n;
    logic [3:0] data_hi;
    logic [15:0] w;
    int bad_count = 0, cmp_count = 0, cyc = 0, n, m, flags = 0;

    aoc_top #(.CAL_CYCLES(CAL)) i_dut (.*);
    aoc_host_model u_host (.*, .data_bit(data_lo[8]));

    always #2.5 core_clk = ~core_clk;
    always @(negedge core_clk)
        if (serial_parallel_select && parallel_bit_eleven === 1'b1) flags++;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tk(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic idle();
        n = 0;
        do begin
            tk(1);
            n++;
        end while (busy !== 1'b0 && n < 400);
        chk("busy_down", n < 400, 1'b1);
    endtask
    task automatic conv(input logic [15:0] v);
        @(posedge core_clk);
        core_result <= v;
        convert_start_n <= 1'b0;
        tk(6);
        chk("busy_up", {busy, sample_hold}, 2'b11);
        @(posedge core_clk);
        convert_start_n <= 1'b1;
        idle();
        chk("busy_len", n + 7 >= CONV_CYCLES, 1'b1);
    endtask
    task automatic par(input logic [3:0] hi, input logic b,
        input logic [10:0] lo);
        u_host.bus(1'b1);
        tk(6);
        chk("d_hi", {data_hi_oe_n, data_hi}, {1'b0, hi});
        chk("d11", parallel_bit_eleven, b);
        chk("d_lo", data_lo, lo);
        u_host.bus(1'b0);
        tk(6);
        chk("oe_off", data_hi_oe_n, 1'b1);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ga, gw, t;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge core_clk);
            ga |= s_axi_awready;
            gw |= s_axi_wready;
            t = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge core_clk);
            s_axi_awvalid <= !ga;
            s_axi_wvalid <= !gw;
        end while (!t);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic g, t;
        g = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            g |= s_axi_arready;
            t = s_axi_rvalid;
            rv = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge core_clk);
            s_axi_arvalid <= !g;
        end while (!t);
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        axi_wr(ADDR_CTRL, 32'h1);
        chk("wr_resp", rr, RESP_OKAY);
        tk(6);
        idle();
        axi_rd(ADDR_RESULT);
        chk("result", rv[15:0], 16'h1234);
        axi_rd(ADDR_STATUS);
        chk("status", rv[3:0], 4'h8);
        axi_rd(8'h40);
        chk("unmapped", rr, RESP_SLVERR);
        par(4'h1, 1'b0, 11'h234);
        conv(16'hA9C3);
        par(4'hA, 1'b1, 11'h1C3);
        // serial slave reads, both clock polarities
        @(posedge core_clk);
        serial_parallel_select <= 1'b1;
        conv(16'hC35A);
        flags = 0;
        u_host.shift(4, 1'b0, w);
        u_host.shift(16, 1'b1, w);
        chk("ser", w, 16'hC35A);
        @(posedge core_clk);
        serial_clock_invert <= 1'b1;
        conv(16'h5AC3);
        u_host.shift(16, 1'b1, w);
        chk("ser_inv", w, 16'h5AC3);
        chk("no_flag", flags, 0);
        conv(16'h0F0F);
        u_host.shift(5, 1'b1, w);
        conv(16'hF00F);
        tk(2);
        chk("flag", flags, 1);
        u_host.shift(16, 1'b1, w);
        chk("fresh", w, 16'hF00F);
        // abort, then calibration with a start that must be ignored
        @(posedge core_clk);
        serial_parallel_select <= 1'b0;
        convert_start_n <= 1'b0;
        tk(20);
        @(posedge core_clk);
        reset_in <= 1'b1;
        tk(8);
        chk("abort", {busy, sample_hold}, 2'b00);
        @(posedge core_clk);
        reset_in <= 1'b0;
        convert_start_n <= 1'b1;
        m = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            if (i == 6)
                convert_start_n <= 1'b0;
            @(negedge core_clk);
            m += (busy === 1'b1);
        end
        chk("cal_len", m, CAL);
        // power-down blocks new starts but lets a running one finish
        @(posedge core_clk);
        convert_start_n <= 1'b1;
        power_down_input <= 1'b1;
        tk(8);
        @(posedge core_clk);
        convert_start_n <= 1'b0;
        tk(20);
        chk("pd_block", {busy, low_power}, 2'b01);
        @(posedge core_clk);
        convert_start_n <= 1'b1;
        power_down_input <= 1'b0;
        tk(8);
        @(posedge core_clk);
        convert_start_n <= 1'b0;
        tk(10);
        @(posedge core_clk);
        power_down_input <= 1'b1;
        idle();
        tk(6);
        chk("pd_fin", {n > 90, low_power}, 2'b11);
        u_host.set_ref(1'b1);
        tk(6);
        chk("ref_off", {ref_enable, refbuf_enable}, 2'b00);
        u_host.set_ref(1'b0);
        tk(6);
        chk("ref_on", {ref_enable, refbuf_enable}, 2'b11);
        complete_run();
    end
endmodule
